// ===== core/pmt_top.sv
// mac-facing data timing of a 10/100 phy: clocks, carrier, sqe, receive latency
`timescale 1ns/1ps
`default_nettype none
module pmt_top (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // resolved link configuration
  input  wire logic              spd_100_i,
  input  wire logic              rmii_mode_i,
  // mac transmit side
  input  wire logic              mac_tx_en_i,
  input  wire pmt_pkg::pmt_nib_t mac_txd_i,
  // clocks toward the mac
  output logic                   mac_txc_o,
  output logic                   mac_rxc_o,
  output logic                   mac_ref_clk_o,
  // mac receive side
  output pmt_pkg::pmt_nib_t      mac_rxd_o,
  output logic                   mac_rx_err_o,
  output logic                   mac_rx_dv_o,
  output logic                   mac_crs_o,
  output logic                   mac_col_o,
  // line transmit stream
  output logic                   line_tx_vld_o,
  output pmt_pkg::pmt_nib_t      line_tx_dat_o,
  input  wire logic              line_tx_rdy_i,
  output logic                   tx_ovf_o,
  // line receive stream
  input  wire logic              line_rx_act_i,
  input  wire pmt_pkg::pmt_nib_t line_rx_dat_i,
  input  wire logic              line_rx_err_i
);
  import pmt_pkg::*;

  logic [4:0]    s1_q, s2_q, s3_q, filt_q;
  logic          txen_f, txen_prev_q;
  logic [1:0]    mode_q;
  logic          mode_chg, fast;
  logic [CW-1:0] div_cnt_q;
  logic          clk_q, rise_p_q, ref_q;
  logic [2:0]    rise_dl_q;
  logic          cap_vld_q, ovf_q;
  pmt_nib_t      cap_dat_q;
  logic          tx_crs_q, crs_q;
  logic [CW-1:0] tx_lat_q;
  pmt_sqe_t      sqe_q;
  logic [CW-1:0] sqe_cnt_q;
  logic          col_q;
  logic [CW-1:0] rx_cnt_q;
  pmt_nib_t      rxd_q;
  logic          rxer_q, rxdv_q;

  pmt_strm_if #(.W(NIB_W)) q_in ();
  pmt_strm_if #(.W(NIB_W)) q_out ();

  function automatic logic [CW-1:0] half_cyc(input logic [1:0] m);
    if (m[1])
      return CW'(REFHALF_CYC);
    else if (m[0])
      return CW'(HALF100_CYC);
    else
      return CW'(HALF10_CYC);
  endfunction

  // the synchroniser already costs SYNC_LAG cycles, so it is taken off here
  function automatic logic [CW-1:0] crs_lat(input logic f, input logic on);
    int c;
    c = f ? (on ? CRS_ON100_CYC : CRS_OFF100_CYC) : (on ? CRS_ON10_CYC : CRS_OFF10_CYC);
    c = c - SYNC_LAG;
    if (c < 1)
      c = 1;
    return CW'(c);
  endfunction

  function automatic logic [CW-1:0] rx_lat(input logic f, input logic [1:0] sel);
    if (!f)
      return CW'(RLAT10_CYC);
    else if (sel == SEL_D)
      return CW'(RXD100_CYC);
    else if (sel == SEL_ER)
      return CW'(RXER100_CYC);
    else
      return CW'(RXDV100_CYC);
  endfunction

  // mac pins: three flops, a change counts once stages two and three agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q   <= 5'h00;
      s2_q   <= 5'h00;
      s3_q   <= 5'h00;
      filt_q <= 5'h00;
    end
    else
    begin
      s1_q <= {mac_tx_en_i, mac_txd_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        filt_q <= s3_q;
    end
  end
  assign txen_f = filt_q[4];

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_q <= MODE_10;
    else
      mode_q <= {rmii_mode_i, spd_100_i};
  end
  assign mode_chg = ({rmii_mode_i, spd_100_i} != mode_q);
  assign fast     = mode_q[0];

  // one divider feeds the mac transmit and receive clocks, restarted on any speed change
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt_q <= '0;
      clk_q     <= 1'b0;
      rise_p_q  <= 1'b0;
    end
    else if (mode_chg)
    begin
      div_cnt_q <= '0;
      clk_q     <= 1'b0;
      rise_p_q  <= 1'b0;
    end
    else if (div_cnt_q == half_cyc(mode_q) - CW'(1))
    begin
      div_cnt_q <= '0;
      clk_q     <= ~clk_q;
      rise_p_q  <= ~clk_q;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + CW'(1);
      rise_p_q  <= 1'b0;
    end
  end
  assign mac_txc_o = clk_q;
  assign mac_rxc_o = clk_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ref_q <= 1'b0;
    else
      ref_q <= ~ref_q;
  end
  assign mac_ref_clk_o = ref_q;

  // capture three cycles after the edge so the filtered value is the one that
  // stood just before that edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rise_dl_q <= 3'h0;
    else
      rise_dl_q <= {rise_dl_q[1:0], rise_p_q};
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cap_vld_q <= 1'b0;
      cap_dat_q <= '0;
      ovf_q     <= 1'b0;
    end
    else
    begin
      ovf_q <= 1'b0;
      if (cap_vld_q && q_in.rdy)
        cap_vld_q <= 1'b0;
      if (rise_dl_q[2] && txen_f)
      begin
        if (cap_vld_q && !q_in.rdy)
          ovf_q <= 1'b1;
        else
        begin
          cap_vld_q <= 1'b1;
          cap_dat_q <= filt_q[3:0];
        end
      end
    end
  end
  assign q_in.vld  = cap_vld_q;
  assign q_in.dat  = cap_dat_q;
  assign q_out.rdy = line_tx_rdy_i;
  assign line_tx_vld_o = q_out.vld;
  assign line_tx_dat_o = q_out.dat;
  assign tx_ovf_o      = ovf_q;

  pmt_fifo #(.W(NIB_W), .D(FIFO_D)) u_fifo (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n_i),
    .wr      (q_in.snk),
    .rd      (q_out.src)
  );

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_crs_q <= 1'b0;
      tx_lat_q <= '0;
    end
    else if (txen_f == tx_crs_q)
      tx_lat_q <= '0;
    else if (tx_lat_q == crs_lat(fast, txen_f) - CW'(1))
    begin
      tx_crs_q <= txen_f;
      tx_lat_q <= '0;
    end
    else
      tx_lat_q <= tx_lat_q + CW'(1);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      crs_q <= 1'b0;
    else
      crs_q <= tx_crs_q | line_rx_act_i;
  end
  assign mac_crs_o = crs_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sqe_q       <= SQE_IDLE;
      sqe_cnt_q   <= '0;
      txen_prev_q <= 1'b0;
    end
    else
    begin
      txen_prev_q <= txen_f;
      unique case (sqe_q)
        SQE_IDLE:
          if (!fast && txen_prev_q && !txen_f)
          begin
            sqe_q     <= SQE_WAIT;
            sqe_cnt_q <= '0;
          end
        SQE_WAIT:
          if (fast || txen_f)
            sqe_q <= SQE_IDLE;
          else if (sqe_cnt_q == CW'(SQE_DLY_CYC - 1))
          begin
            sqe_q     <= SQE_PULSE;
            sqe_cnt_q <= '0;
          end
          else
            sqe_cnt_q <= sqe_cnt_q + CW'(1);
        SQE_PULSE:
          if (fast || sqe_cnt_q == CW'(SQE_PW_CYC - 1))
            sqe_q <= SQE_IDLE;
          else
            sqe_cnt_q <= sqe_cnt_q + CW'(1);
        default:
          sqe_q <= SQE_IDLE;
      endcase
    end
  end

  // half-duplex collision as well as the heartbeat
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      col_q <= 1'b0;
    else
      col_q <= (sqe_q == SQE_PULSE && !fast) | (txen_f & line_rx_act_i);
  end
  assign mac_col_o = col_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rx_cnt_q <= '0;
    else if (!line_rx_act_i)
      rx_cnt_q <= '0;
    else if (rx_cnt_q != '1)
      rx_cnt_q <= rx_cnt_q + CW'(1);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rxd_q  <= '0;
      rxer_q <= 1'b0;
      rxdv_q <= 1'b0;
    end
    else if (rise_p_q)
    begin
      rxd_q  <= (line_rx_act_i && rx_cnt_q >= rx_lat(fast, SEL_D)) ? line_rx_dat_i : '0;
      rxer_q <= line_rx_act_i && line_rx_err_i && rx_cnt_q >= rx_lat(fast, SEL_ER);
      rxdv_q <= line_rx_act_i && rx_cnt_q >= rx_lat(fast, SEL_DV);
    end
  end
  assign mac_rxd_o    = rxd_q;
  assign mac_rx_err_o = rxer_q;
  assign mac_rx_dv_o  = rxdv_q;

  // helper counters read only by the checks below
  logic [CW-1:0] hi_len_q, off_run_q, col_run_q;
  logic          clean_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hi_len_q  <= '0;
      off_run_q <= '0;
      col_run_q <= '0;
      clean_q   <= 1'b0;
    end
    else
    begin
      hi_len_q  <= rise_p_q ? CW'(1) : (clk_q ? hi_len_q + CW'(1) : hi_len_q);
      off_run_q <= txen_f ? '0 : ((off_run_q == '1) ? off_run_q : off_run_q + CW'(1));
      col_run_q <= col_q ? col_run_q + CW'(1) : '0;
      clean_q   <= mode_chg ? 1'b0 : (rise_p_q ? 1'b1 : clean_q);
    end
  end

  property p_half_10;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $fell(mac_txc_o) && clean_q && mode_q == MODE_10 |-> hi_len_q == CW'(HALF10_CYC);
  endproperty
  a_half_10: assert property (p_half_10) else $error("10M clock half period wrong");

  property p_half_100;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(mac_txc_o) && mode_q == MODE_100 && !mode_chg |=> mac_txc_o ##1 !mac_txc_o && !mac_rxc_o;
  endproperty
  a_half_100: assert property (p_half_100) else $error("100M clock half period wrong");

  property p_cap_edge;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(cap_vld_q) |-> $past(rise_dl_q[2]) && $past(txen_f);
  endproperty
  a_cap_edge: assert property (p_cap_edge) else $error("capture off the rising edge");

  property p_rx_launch;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $changed({mac_rxd_o, mac_rx_err_o, mac_rx_dv_o}) |-> $past(rise_p_q) && $past(mac_rxc_o);
  endproperty
  a_rx_launch: assert property (p_rx_launch) else $error("receive outputs moved off edge");

  property p_sqe_time;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(mac_col_o) && !line_rx_act_i && !fast |-> off_run_q == CW'(SQE_DLY_CYC + 2);
  endproperty
  a_sqe_time: assert property (p_sqe_time) else $error("sqe delay wrong");

  property p_sqe_len;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $fell(mac_col_o) && !line_rx_act_i && !fast |-> col_run_q == CW'(SQE_PW_CYC);
  endproperty
  a_sqe_len: assert property (p_sqe_len) else $error("sqe pulse length wrong");

  property p_crs_10;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(txen_f) && mode_q == MODE_10 && !tx_crs_q && !line_rx_act_i |-> ##12 !mac_crs_o ##1 mac_crs_o;
  endproperty
  a_crs_10: assert property (p_crs_10) else $error("10M carrier on latency wrong");

  property p_crs_10_off;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $fell(txen_f) && mode_q == MODE_10 && tx_crs_q && !line_rx_act_i |-> ##47 mac_crs_o ##1 !mac_crs_o;
  endproperty
  a_crs_10_off: assert property (p_crs_10_off) else $error("10M carrier off latency wrong");

  property p_crs_100;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(txen_f) && fast && !tx_crs_q && !line_rx_act_i |-> ##1 !mac_crs_o ##1 mac_crs_o;
  endproperty
  a_crs_100: assert property (p_crs_100) else $error("100M carrier on latency wrong");

  property p_rlat_10;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(mac_rx_dv_o) && mode_q == MODE_10 |->
        $past(rx_cnt_q) >= CW'(RLAT10_CYC) && $past(rx_cnt_q) <= CW'(RLAT10_CYC + 2 * HALF10_CYC);
  endproperty
  a_rlat_10: assert property (p_rlat_10) else $error("10M receive latency wrong");

  property p_rlat_100;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(mac_rx_dv_o) && fast |->
        $past(rx_cnt_q) >= CW'(RXDV100_CYC) && $past(rx_cnt_q) <= CW'(RXDV100_CYC + 2 * HALF100_CYC);
  endproperty
  a_rlat_100: assert property (p_rlat_100) else $error("100M valid latency wrong");

  property p_ref;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> mac_ref_clk_o != $past(mac_ref_clk_o);
  endproperty
  a_ref: assert property (p_ref) else $error("reference clock not 20 ns");

  property p_rmii_rate;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(mac_txc_o) && mode_q[1] && !mode_chg |=> !mac_txc_o;
  endproperty
  a_rmii_rate: assert property (p_rmii_rate) else $error("clock rate ignores mode");

  property p_no_sqe_100;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      fast ##1 fast |=> sqe_q == SQE_IDLE && (!mac_col_o || $past(txen_f && line_rx_act_i));
  endproperty
  a_no_sqe_100: assert property (p_no_sqe_100) else $error("sqe seen at 100M");
endmodule
`default_nettype wire

// ===== core/pmt_pkg.sv
// constants and types for the mac-facing phy timing block
package pmt_pkg;
  localparam int CLK_NS        = 10;
  localparam int SYNC_LAG      = 4;
  localparam int CW            = 12;
  localparam int NIB_W         = 4;
  localparam int FIFO_D        = 4;
  localparam int T10_PER_NS    = 400;
  localparam int T10_HALF_NS   = 200;
  localparam int T100_PER_NS   = 40;
  localparam int T100_HALF_NS  = 20;
  localparam int TREF_PER_NS   = 20;
  localparam int SQE_DLY_NS    = 2500;
  localparam int SQE_PW_NS     = 1000;
  localparam int CRS_ON10_NS   = 160;
  localparam int CRS_OFF10_NS  = 510;
  localparam int CRS_ON100_NS  = 34;
  localparam int CRS_OFF100_NS = 33;
  localparam int RLAT10_NS     = 6500;
  localparam int RXD100_NS     = 52;
  localparam int RXER100_NS    = 60;
  localparam int RXDV100_NS    = 140;
  localparam int HALF10_CYC    = T10_HALF_NS / CLK_NS;
  localparam int HALF100_CYC   = T100_HALF_NS / CLK_NS;
  localparam int REFHALF_CYC   = TREF_PER_NS / (2 * CLK_NS);
  localparam int SQE_DLY_CYC   = (SQE_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SQE_PW_CYC    = (SQE_PW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CRS_ON10_CYC  = (CRS_ON10_NS + CLK_NS - 1) / CLK_NS;
  localparam int CRS_OFF10_CYC = (CRS_OFF10_NS + CLK_NS - 1) / CLK_NS;
  localparam int CRS_ON100_CYC = (CRS_ON100_NS + CLK_NS - 1) / CLK_NS;
  localparam int CRS_OFF100_CYC = (CRS_OFF100_NS + CLK_NS - 1) / CLK_NS;
  localparam int RLAT10_CYC    = (RLAT10_NS + CLK_NS - 1) / CLK_NS;
  localparam int RXD100_CYC    = (RXD100_NS + CLK_NS - 1) / CLK_NS;
  localparam int RXER100_CYC   = (RXER100_NS + CLK_NS - 1) / CLK_NS;
  localparam int RXDV100_CYC   = (RXDV100_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] MODE_10  = 2'h0;
  localparam logic [1:0] MODE_100 = 2'h1;
  localparam logic [1:0] SEL_D    = 2'h0;
  localparam logic [1:0] SEL_ER   = 2'h1;
  localparam logic [1:0] SEL_DV   = 2'h2;
  typedef logic [NIB_W-1:0] pmt_nib_t;
  typedef enum logic [2:0] {
    SQE_IDLE  = 3'h1,
    SQE_WAIT  = 3'h2,
    SQE_PULSE = 3'h4
  } pmt_sqe_t;
endpackage

// ===== core/pmt_strm_if.sv
// valid/ready nibble stream between the block's own modules
`timescale 1ns/1ps
`default_nettype none
interface pmt_strm_if #(parameter int W = 4);
  logic         vld;
  logic         rdy;
  logic [W-1:0] dat;
  modport snk (input vld, input dat, output rdy);
  modport src (output vld, output dat, input rdy);
endinterface
`default_nettype wire

// ===== core/pmt_fifo.sv
// small transmit nibble fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module pmt_fifo #(
  parameter int W = 4,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  // stream sides
  pmt_strm_if.snk     wr,
  pmt_strm_if.src     rd
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          ovld_q;
  logic [W-1:0]  odat_q;
  logic          push;
  logic          pop;

  assign wr.rdy = (cnt_q != (AW+1)'(D));
  assign push   = wr.vld && wr.rdy;
  // refill the output register whenever it is empty or being taken
  assign pop    = (cnt_q != '0) && (!ovld_q || rd.rdy);
  assign rd.vld = ovld_q;
  assign rd.dat = odat_q;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wp_q] <= wr.dat;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= wp_q + AW'(1);
      end
      if (pop)
      begin
        rp_q <= rp_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ovld_q <= 1'b0;
      odat_q <= '0;
    end
    else if (pop)
    begin
      ovld_q <= 1'b1;
      odat_q <= mem_q[rp_q];
    end
    else if (rd.rdy)
    begin
      ovld_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== verif/pmt_mac_model.sv
// behavioural mac transmit side: sends a numbered nibble frame on the phy transmit clock
`timescale 1ns/1ps
`default_nettype none
module pmt_mac_model (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // frame request from the bench
  input  wire logic              start_i,
  input  wire logic [4:0]        cnt_i,
  input  wire pmt_pkg::pmt_nib_t base_i,
  // phy facing pins
  input  wire logic              txc_i,
  output logic                   tx_en_o,
  output pmt_pkg::pmt_nib_t      txd_o
);
  import pmt_pkg::*;
  logic       txc_q;
  logic [4:0] left_q;
  pmt_nib_t   nib_q;
  // pins move only after a clock rise, so they are settled for the next rise
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      txc_q   <= 1'b0;
      left_q  <= 5'h00;
      nib_q   <= 4'h0;
      tx_en_o <= 1'b0;
      txd_o   <= 4'h0;
    end
    else
    begin
      txc_q <= txc_i;
      if (txc_i && !txc_q)
      begin
        if (left_q != 5'h00)
        begin
          tx_en_o <= 1'b1;
          txd_o   <= nib_q;
          nib_q   <= nib_q + 4'h1;
          left_q  <= left_q - 5'h01;
        end
        else
        begin
          // idle data keeps moving so a stale nibble can never look valid
          tx_en_o <= 1'b0;
          txd_o   <= ~txd_o;
          if (start_i)
          begin
            left_q <= cnt_i;
            nib_q  <= base_i;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/pmt_top_tb.sv
// self-checking bench for the mac-facing phy timing block
`timescale 1ns/1ps
`default_nettype none
module pmt_top_tb;
  import pmt_pkg::*;
  typedef struct {logic spd; logic rmii; int half; int on; int off; bit sqe; int lat; int dvl;} pmt_row_t;
  logic       sys_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       spd     = 1'b0;
  logic       rmii    = 1'b0;
  logic       rdy     = 1'b1;
  logic       act     = 1'b0;
  logic       rx_err  = 1'b0;
  logic       start   = 1'b0;
  logic [4:0] cnt     = 5'h00;
  pmt_nib_t   base    = 4'h0;
  pmt_nib_t   rx_dat  = 4'h0;
  pmt_nib_t   txd, rxd, line_dat;
  logic       tx_en, txc, rxc, refc, err, dv, crs, col, vld, ovf, r, rxc_q, rxc_rise_q;
  logic [5:0] rxv_q   = 6'h00;
  int         fail_count = 0;
  int         compares   = 0;
  int         cyc        = 0;
  int         t0;
  bit         hit;
  pmt_nib_t   q[$];
  pmt_row_t   rows[4];

  pmt_top i_pmt_top (
    .sys_clk_i     (sys_clk),
    .rst_n_i       (rst_n),
    .spd_100_i     (spd),
    .rmii_mode_i   (rmii),
    .mac_tx_en_i   (tx_en),
    .mac_txd_i     (txd),
    .mac_txc_o     (txc),
    .mac_rxc_o     (rxc),
    .mac_ref_clk_o (refc),
    .mac_rxd_o     (rxd),
    .mac_rx_err_o  (err),
    .mac_rx_dv_o   (dv),
    .mac_crs_o     (crs),
    .mac_col_o     (col),
    .line_tx_vld_o (vld),
    .line_tx_dat_o (line_dat),
    .line_tx_rdy_i (rdy),
    .tx_ovf_o      (ovf),
    .line_rx_act_i (act),
    .line_rx_dat_i (rx_dat),
    .line_rx_err_i (rx_err)
  );
  pmt_mac_model i_pmt_mac_model (
    .sys_clk_i (sys_clk),
    .rst_n_i   (rst_n),
    .start_i   (start),
    .cnt_i     (cnt),
    .base_i    (base),
    .txc_i     (txc),
    .tx_en_o   (tx_en),
    .txd_o     (txd)
  );

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  always @(posedge sys_clk) if (vld === 1'b1 && rdy) q.push_back(line_dat);

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_nib(input string nm, input pmt_nib_t e, input pmt_nib_t g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_near(input string nm, input int e, input int g, input int tol);
    compares++;
    if (g < e - tol || g > e + tol)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return txc;
      1: return crs;
      2: return col;
      3: return dv;
      4: return err;
      5: return rxd != 4'h0;
      6: return ovf;
      7: return vld;
      default: return tx_en;
    endcase
  endfunction
  // every wait is bounded; a required event that never comes ends the run
  task automatic wait_sig(input int s, input logic v, input int bound, input bit must, output bit got);
    got = 1'b0;
    for (int n = 0; n < bound && !got; n++)
    begin
      @(posedge sys_clk);
      #1;
      got = (sig(s) === v);
    end
    if (!got && must)
    begin
      fail_count++;
      $display("[FAIL] wait_sig_%0d expected %b seen timeout", s, v);
      final_report();
    end
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    chk_bit("reset_outs", 1'b0, crs | col | dv | vld | ovf | txc | rxc | err);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  // receive outputs are registered one cycle after the receive clock rises
  always @(posedge sys_clk)
  begin
    #1;
    if (rst_n && {rxd, err, dv} !== rxv_q) chk_bit("rx_launch", 1'b1, rxc_rise_q);
    rxv_q      = {rxd, err, dv};
    rxc_rise_q = rxc & ~rxc_q;
    rxc_q      = rxc;
  end

  initial
  begin
    rows[0] = '{1'b0, 1'b0, HALF10_CYC, CRS_ON10_CYC, CRS_OFF10_CYC, 1'b1, RLAT10_CYC, RLAT10_CYC};
    rows[1] = '{1'b1, 1'b0, HALF100_CYC, CRS_ON100_CYC, CRS_OFF100_CYC, 1'b0, RXD100_CYC, RXDV100_CYC};
    rows[2] = '{1'b1, 1'b1, REFHALF_CYC, 0, 0, 1'b0, RXD100_CYC, RXDV100_CYC};
    // reduced-pin clocks with slow-link latencies
    rows[3] = '{1'b0, 1'b1, REFHALF_CYC, 0, 0, 1'b0, RLAT10_CYC, RLAT10_CYC};
    do_reset();
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      spd  <= rows[i].spd;
      rmii <= rows[i].rmii;
      wait_sig(0, 1'b0, 100, 1, hit);
      wait_sig(0, 1'b1, 100, 1, hit);
      t0 = cyc;
      wait_sig(0, 1'b0, 100, 1, hit);
      chk_near("txc_high", rows[i].half, cyc - t0, 0);
      t0 = cyc;
      r = refc;
      wait_sig(0, 1'b1, 100, 1, hit);
      chk_near("txc_low", rows[i].half, cyc - t0, 0);
      chk_bit("rxc_with_txc", txc, rxc);
      chk_bit("ref_toggle", r ^ rows[i].half[0], refc);
      if (rows[i].on != 0)
      begin
        q.delete();
        cnt   <= 5'h08;
        base  <= 4'h3;
        start <= 1'b1;
        wait_sig(8, 1'b1, 200, 1, hit);
        t0 = cyc;
        start <= 1'b0;
        wait_sig(1, 1'b1, 100, 1, hit);
        chk_near("crs_on", rows[i].on, cyc - t0, 3);
        wait_sig(8, 1'b0, 1000, 1, hit);
        t0 = cyc;
        wait_sig(1, 1'b0, 100, 1, hit);
        chk_near("crs_off", rows[i].off, cyc - t0, 3);
        wait_sig(2, 1'b1, 400, 0, hit);
        chk_bit("sqe_seen", rows[i].sqe, hit);
        if (hit)
        begin
          chk_near("sqe_delay", SQE_DLY_CYC, cyc - t0, 8);
          t0 = cyc;
          wait_sig(2, 1'b0, 200, 1, hit);
          chk_near("sqe_width", SQE_PW_CYC, cyc - t0, 1);
        end
        chk_near("tx_count", 8, q.size(), 0);
        foreach (q[k]) chk_nib("tx_nibble", 4'h3 + 4'(k), q[k]);
      end
      @(posedge sys_clk);
      rx_dat <= 4'hA;
      rx_err <= 1'b1;
      act    <= 1'b1;
      wait_sig(1, 1'b1, 4, 1, hit);
      t0 = cyc;
      wait_sig(5, 1'b1, 800, 1, hit);
      chk_near("rxd_lat", rows[i].lat, cyc - t0, 2 * rows[i].half + 1);
      wait_sig(4, 1'b1, 800, 1, hit);
      chk_near("rxer_lat", rows[i].lat, cyc - t0, 2 * rows[i].half + 2);
      wait_sig(3, 1'b1, 800, 1, hit);
      chk_near("rxdv_lat", rows[i].dvl, cyc - t0, 2 * rows[i].half + 2);
      chk_nib("rxd_data", 4'hA, rxd);
      @(posedge sys_clk);
      act    <= 1'b0;
      rx_err <= 1'b0;
      wait_sig(3, 1'b0, 2 * rows[i].half + 4, 1, hit);
    end
    // stall the line side until captures are refused, then drain in order
    @(posedge sys_clk);
    spd   <= 1'b1;
    rmii  <= 1'b0;
    rdy   <= 1'b0;
    cnt   <= 5'h0C;
    base  <= 4'h0;
    start <= 1'b1;
    q.delete();
    wait_sig(8, 1'b1, 100, 1, hit);
    start <= 1'b0;
    wait_sig(6, 1'b1, 200, 1, hit);
    chk_bit("ovf_seen", 1'b1, hit);
    wait_sig(8, 1'b0, 200, 1, hit);
    wait_sig(6, 1'b1, 8, 0, hit);
    @(posedge sys_clk);
    rdy <= 1'b1;
    wait_sig(7, 1'b0, 50, 1, hit);
    // fifo words plus its output register plus the capture register
    chk_near("fifo_held", FIFO_D + 2, q.size(), 0);
    foreach (q[k]) chk_nib("fifo_order", 4'(k), q[k]);
    // reset again in mid-frame with the line side stalled
    @(posedge sys_clk);
    rdy   <= 1'b0;
    start <= 1'b1;
    wait_sig(8, 1'b1, 100, 1, hit);
    start <= 1'b0;
    wait_sig(7, 1'b1, 50, 1, hit);
    do_reset();
    rdy <= 1'b1;
    #1;
    chk_bit("vld_after_reset", 1'b0, vld);
    final_report();
  end
endmodule
`default_nettype wire
